// [logic/dac_serial_pkg.sv]
// shared constants and carrier types for the daisy-chain dac serial port
package dac_serial_pkg;
    localparam int unsigned SHIFT_WIDTH   = 16;
    localparam int unsigned LATCH_WIDTH   = 12;
    localparam int unsigned CODE_WIDTH    = 10;
    localparam int unsigned SUB_LSB_WIDTH = 2;
    localparam int unsigned LATCH_LSB     = 0;
    localparam logic [LATCH_WIDTH-1:0] DAC_RESET = 12'h000;
    localparam logic [SHIFT_WIDTH-1:0] SHIFT_RESET = 16'h0000;
    localparam logic                   DOUT_RESET  = 1'b0;

    // serial pins, raw and after synchronisation
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } serial_pins_s;

    // synchroniser idle levels: clock low, select high, data low
    localparam serial_pins_s SYNC_RESET = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};

    // detected events on the serial pins
    typedef struct packed {
        logic sclk_rise;
        logic sclk_fall;
        logic cs_rise;
    } serial_events_s;
endpackage : dac_serial_pkg

// [logic/pin_sync.sv]
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync needs at least one bit");
        end
    end

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : pin_sync
`default_nettype wire

// [logic/dac_serial_daisy_chain_port.sv]
// serial write port with daisy-chain output of a 10-bit dac
// Overview of operation
// [R1] a bit taken on the serial input leaves the serial output sixteen clocks and one width later; here fifteen and a half clocks later.
// [R2] with select low the serial output changes only on falling serial clock edges.
// [R3] with select high the serial output holds the last bit shifted out.
// [R4] the serial output is always driven high or low, never released.
// [R5] chained parts wire output to next input and share clock and select.
// [R6] the host may read the serial output back but need not.
// [R7] the host should load all zeros when the converter is idle to save power.
// [R8] with select low each rising serial clock shifts one bit in, most significant first.
// [R9] the rising edge of select copies the shift register into the dac register.
// [R10] with select high serial clock edges are ignored and nothing shifts.
// [R11] the host sends the ten-bit code followed by two zero sub-lsb bits.
// [R12] for a chain the host shifts sixteen bits per device, farthest first, then raises select.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_daisy_chain_port #(
    parameter int unsigned SHIFT_BITS = dac_serial_pkg::SHIFT_WIDTH,
    parameter int unsigned LATCH_BITS = dac_serial_pkg::LATCH_WIDTH
) (
    input  wire logic                                   i_ref_clk,
    input  wire logic                                   i_rst,
    input  wire logic                                   i_sclk,
    input  wire logic                                   i_cs_n,
    input  wire logic                                   i_din,
    output logic                                        o_dout,
    output logic                                        o_dout_oe,
    output logic [dac_serial_pkg::CODE_WIDTH-1:0]       o_dac_code,
    output logic                                        o_dac_update
);
    initial begin
        if (SHIFT_BITS != dac_serial_pkg::SHIFT_WIDTH || LATCH_BITS > SHIFT_BITS
            || LATCH_BITS != dac_serial_pkg::LATCH_WIDTH) begin
            $error("unsupported shift or latch width");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    dac_serial_pkg::serial_pins_s   pins_raw;
    dac_serial_pkg::serial_pins_s   pins_sync;
    dac_serial_pkg::serial_pins_s   pins_prev_q;
    dac_serial_pkg::serial_events_s events;

    assign pins_raw.sclk = i_sclk;
    assign pins_raw.cs_n = i_cs_n;
    assign pins_raw.din  = i_din;

    // select idles high so reset does not fake a select edge
    pin_sync #(
        .WIDTH       (3),
        .RESET_VALUE (dac_serial_pkg::SYNC_RESET)
    ) u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   (pins_raw),
        .o_sync    (pins_sync)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pins_prev_q <= dac_serial_pkg::SYNC_RESET;
        end else begin
            pins_prev_q <= pins_sync;
        end
    end

    // high when a synchronised level has just gone from low to high
    function automatic logic edge_seen(input logic now_lvl, input logic before_lvl);
        return now_lvl & ~before_lvl;
    endfunction : edge_seen

    wire selected = ~pins_sync.cs_n;

    assign events.sclk_rise = edge_seen(pins_sync.sclk, pins_prev_q.sclk) & selected;   // [R10]
    assign events.sclk_fall = edge_seen(pins_prev_q.sclk, pins_sync.sclk) & selected;   // [R10]
    assign events.cs_rise   = edge_seen(pins_sync.cs_n, pins_prev_q.cs_n);

    ////////////////////////////////////////////////////////////////////////////////
    // input shift register and output stage

    logic [SHIFT_BITS-1:0] shift_q;
    logic [SHIFT_BITS-1:0] shift_d;
    logic                  dout_q;
    logic                  dout_d;

    assign shift_d = events.sclk_rise ? {shift_q[SHIFT_BITS-2:0], pins_sync.din}
                                      : shift_q;                              // [R8]
    // top stage after the sixteenth rise is shown at the following fall
    assign dout_d  = events.sclk_fall ? shift_q[SHIFT_BITS-1] : dout_q;         // [R1] [R2] [R3]

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            shift_q <= dac_serial_pkg::SHIFT_RESET;
            dout_q  <= dac_serial_pkg::DOUT_RESET;
        end else begin
            shift_q <= shift_d;
            dout_q  <= dout_d;
        end
    end

    assign o_dout    = dout_q;
    assign o_dout_oe = 1'b1;                                                    // [R4]

    ////////////////////////////////////////////////////////////////////////////////
    // dac register

    logic [LATCH_BITS-1:0] dac_q;
    logic [LATCH_BITS-1:0] dac_d;
    logic                  update_q;

    assign dac_d = events.cs_rise ? shift_q[LATCH_BITS-1:0] : dac_q;            // [R9]

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            dac_q    <= dac_serial_pkg::DAC_RESET;
            update_q <= 1'b0;
        end else begin
            dac_q    <= dac_d;
            update_q <= events.cs_rise;
        end
    end

    // sub-lsb bits are dropped from the code
    assign o_dac_code   = dac_q[LATCH_BITS-1 -: dac_serial_pkg::CODE_WIDTH];
    assign o_dac_update = update_q;
endmodule : dac_serial_daisy_chain_port
`default_nettype wire

// [tb/dac_port_properties.sv]
// pin-level assertions for the dac serial port
`timescale 1ns/1ps
`default_nettype none
module dac_port_properties (
    input wire logic                                i_ref_clk,
    input wire logic                                i_rst,
    input wire logic                                i_sclk,
    input wire logic                                i_cs_n,
    input wire logic                                i_din,
    input wire logic                                o_dout,
    input wire logic                                o_dout_oe,
    input wire logic [dac_serial_pkg::CODE_WIDTH-1:0] o_dac_code,
    input wire logic                                o_dac_update
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_oe_always: assert property (o_dout_oe) else $error("dout released");
    a_dout_fall: assert property ($changed(o_dout) |-> !$past(i_sclk, 3) && $past(i_sclk, 4))
        else $error("dout moved off sclk fall");
    a_dout_select: assert property ($changed(o_dout) |-> !$past(i_cs_n, 3))
        else $error("dout moved unselected");
    a_dout_hold: assert property (i_cs_n [*6] |=> $stable(o_dout)) else $error("dout drift");
    a_idle_no_load: assert property (i_cs_n [*6] |=> $stable(o_dac_code))
        else $error("code moved idle");
    a_load_on_select: assert property ($rose(i_cs_n) |-> ##[2:5] o_dac_update)
        else $error("no load");
    a_code_pulse: assert property ($changed(o_dac_code) |-> ##[0:2] o_dac_update)
        else $error("code without pulse");
    cover property ($rose(i_cs_n));
    cover property (o_dac_update && o_dac_code == 10'h000);
    cover property ($changed(o_dout));
endmodule : dac_port_properties
`default_nettype wire

// [tb/host_model.sv]
// host serial port driving the dac pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_dout,
    output var  logic        o_sclk,
    output var  logic        o_cs_n,
    output var  logic        o_din,
    output var  logic [15:0] o_rx
);
    initial {o_sclk, o_cs_n, o_din, o_rx} = {3'h2, 16'h0000};
    task automatic half();
        repeat (8) @(negedge i_ref_clk);
    endtask : half
    // sel low keeps select high while clocking
    task automatic frame(input logic [15:0] w, input int n, input logic sel);
        half();
        o_cs_n = !sel;
        for (int i = n - 1; i >= 0; i--) begin
            o_din = w[i];
            half();
            o_sclk = 1'b1;
            o_rx = {o_rx[14:0], i_dout};
            half();
            o_sclk = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        o_din = ~o_din;
        half();
    endtask : frame
endmodule : host_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the dac serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sclk, cs_n, din, dout, oe, upd;
    int          updates = 0;
    logic [9:0]  code;
    logic [15:0] rx;
    int          errors = 0;
    int          samples_checked = 0;
    initial forever #5 clk = ~clk;
    always @(negedge clk) if (upd === 1'b1) updates++;
    dac_serial_daisy_chain_port DUT (.i_ref_clk(clk), .i_rst(rst), .i_sclk(sclk),
        .i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_dout_oe(oe), .o_dac_code(code),
        .o_dac_update(upd));
    host_model host (.i_ref_clk(clk), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n),
        .o_din(din), .o_rx(rx));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic test_load();
        logic [9:0] codes [3] = '{10'h3FF, 10'h201, 10'h000};
        int seen;
        foreach (codes[i]) begin
            seen = updates;
            host.frame({4'h0, codes[i], 2'h0}, (i == 1) ? 16 : 12, 1'b1);
            chk({6'h00, code}, {6'h00, codes[i]});
            chk(16'(updates - seen), 16'h0001);
        end
        $display("test_load done");
    endtask : test_load
    task automatic test_chain();
        int seen;
        host.frame(16'hA5C3, 16, 1'b1);
        seen = updates;
        host.frame(16'hFFFF, 16, 1'b0);
        chk({15'h0000, dout}, 16'h0001);
        chk(16'(updates - seen), 16'h0000);
        host.frame(16'h0000, 16, 1'b1);
        chk(rx, 16'hA5C3);
        chk({15'h0000, dout}, 16'h0000);
        chk({15'h0000, oe}, 16'h0001);
        chk({6'h00, code}, 16'h0000);
        $display("test_chain done");
    endtask : test_chain
    initial begin
        #100000;
        errors++;
        conclude();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        test_load();
        test_chain();
        conclude();
    end
endmodule : tb
bind dac_serial_daisy_chain_port dac_port_properties props (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_din(i_din), .o_dout(o_dout),
    .o_dout_oe(o_dout_oe), .o_dac_code(o_dac_code), .o_dac_update(o_dac_update));
`default_nettype wire
